// file: fis_defs.vh
// constants for the flash identification, parameter-table and security-area command block
// Function
// - opcode 9Fh returns maker, memory-type, capacity bytes, MSB first, on falling edges
// - opcode 5Ah: 24-bit address, eight dummy clocks, table data after clock 40
// - table read address bits 23..8 are zero; bits 7..0 pick the starting byte
// - area address: upper byte 00h, bits 11..8 zero, bits 15..12 pick area 1-3
// - area erase 44h is accepted only while the write latch flag is set
// - erase runs only when select rises right after the last address bit
// - valid erase runs self-timed with busy set; status reads still work
// - end of an erase cycle clears busy and the write latch flag
// - set lock bits are permanent and block erase and program of their area
// - area program 42h needs the write latch flag; 1 to 256 data bytes follow
// - area read 48h: address, eight dummy clocks, data MSB first on falling edges
// - area read advances the byte position and wraps FFh to 00h in the area
// - area read issued while busy is ignored and leaves the cycle untouched
// - read-parameter C0h is accepted only in quad command mode
// - dummy field 00/01/10/11 gives 2/4/6/8 dummy clocks
// - wrap field 00/01/10/11 gives 8/16/32/64 byte wrap
// - power-up and software reset give 8-byte wrap and 8 dummy clocks (dummy field 00, serial mode)
// - programmed dummy count applies only to 0Bh, EBh and 0Ch reads
// - wrap length set by 77h in serial mode survives the switch to quad mode
// - software reset restores the read parameter setting to its default
// - quad mode entry is accepted only while the quad enable flag is set
`ifndef FIS_DEFS_VH
`define FIS_DEFS_VH

// opcodes
`define FIS_OP_NONE      8'h00
`define FIS_OP_JEDEC_ID  8'h9F
`define FIS_OP_PARAM_RD  8'h5A
`define FIS_OP_SEC_ERASE 8'h44
`define FIS_OP_SEC_PROG  8'h42
`define FIS_OP_SEC_READ  8'h48
`define FIS_OP_SET_RDPAR 8'hC0
`define FIS_OP_SET_WRAP  8'h77
`define FIS_OP_QUAD_IN   8'h38
`define FIS_OP_QUAD_OUT  8'hFF
`define FIS_OP_WR_EN     8'h06
`define FIS_OP_WR_DIS    8'h04
`define FIS_OP_STAT1     8'h05
`define FIS_OP_STAT2     8'h35
`define FIS_OP_RST_EN    8'h66
`define FIS_OP_RST       8'h99
`define FIS_OP_FAST_RD   8'h0B
`define FIS_OP_QIO_RD    8'hEB
`define FIS_OP_BURST_RD  8'h0C

// serial framing, in bits and bytes since select fell
`define FIS_ERASE_BITS   12'd32
`define FIS_PROG_MIN_BIT 12'd40
`define FIS_DATA_BYTE    9'd5
`define FIS_ADDR_BYTE    9'd4

// read parameter fields and defaults
`define FIS_DUMMY_MSB    5
`define FIS_DUMMY_LSB    4
`define FIS_WRAP_MSB     1
`define FIS_WRAP_LSB     0
`define FIS_DUMMY_RST    2'b00
`define FIS_WRAP_RST     2'b00
`define FIS_SPI_DUMMY    4'h8

// timing
`define FIS_CLK_NS       10
`define FIS_ERASE_US     100
`define FIS_PROG_US      50
`define FIS_AREA_BYTES   20'd256

// register map, byte addresses
`define FIS_REG_STATUS   8'h00
`define FIS_REG_CONFIG   8'h04
`define FIS_REG_RDPAR    8'h08
`define FIS_REG_LASTOP   8'h0C

`endif

// file: fis_flash_cmd.v
// serial flash command block: identification, parameter table, security areas, read parameters
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fis_defs.vh"

module fis_flash_cmd #(
	parameter [19:0] ERASE_CYCLES = (`FIS_ERASE_US * 1000) / `FIS_CLK_NS,
	parameter [19:0] PROG_CYCLES  = (`FIS_PROG_US * 1000) / `FIS_CLK_NS,
	parameter [7:0]  MFR_ID       = 8'hA5, // arbitrary value
	parameter [7:0]  MEM_TYPE_ID  = 8'h5A, // arbitrary value
	parameter [7:0]  CAPACITY_ID  = 8'h13  // arbitrary value
)(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        select_n,
	input  wire        serial_clk,
	input  wire        serial_in_line,
	output reg         serial_out,
	output reg         serial_out_oe_n,
	output reg  [3:0]  read_dummy_clocks,
	output reg  [6:0]  wrap_bytes
);

	// =========================================================
	// functions
	// dummy field decode
	function [3:0] fis_dummy;
		input [1:0] f;
		begin
			case (f)
				2'b00:   fis_dummy = 4'h2;
				2'b01:   fis_dummy = 4'h4;
				2'b10:   fis_dummy = 4'h6;
				default: fis_dummy = 4'h8;
			endcase
		end
	endfunction

	// wrap field decode
	function [6:0] fis_wrap;
		input [1:0] f;
		begin
			case (f)
				2'b00:   fis_wrap = 7'h08;
				2'b01:   fis_wrap = 7'h10;
				2'b10:   fis_wrap = 7'h20;
				default: fis_wrap = 7'h40;
			endcase
		end
	endfunction

	// area number 1..3 from a 24-bit address, 0 when the address is not an area
	function [1:0] fis_area;
		input [23:0] a;
		begin
			if (a[23:16] == 8'h00 && a[11:8] == 4'h0 && a[15:12] >= 4'h1 && a[15:12] <= 4'h3)
				fis_area = a[13:12];
			else
				fis_area = 2'b00;
		end
	endfunction

	// discoverable parameter table contents; unused bytes read FFh
	function [7:0] fis_table;
		input [7:0] p;
		begin
			case (p)
				8'h00:   fis_table = 8'h53;
				8'h01:   fis_table = 8'h46;
				8'h02:   fis_table = 8'h44;
				8'h03:   fis_table = 8'h50;
				8'h04:   fis_table = 8'h00;
				8'h05:   fis_table = 8'h01;
				8'h06:   fis_table = 8'h00;
				default: fis_table = 8'hFF;
			endcase
		end
	endfunction

	// =========================================================
	// pin synchronisers
	reg  sclk_s1, sclk_s2, sclk_s3;
	reg  sel_s1, sel_s2, sel_s3;
	reg  si_s1, si_s2;

	// two flops per pin, third flop only for edge finding on the synced level
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			sel_s1  <= 1'b1;
			sel_s2  <= 1'b1;
			sel_s3  <= 1'b1;
			si_s1   <= 1'b0;
			si_s2   <= 1'b0;
		end
		else
		begin
			sclk_s1 <= serial_clk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			sel_s1  <= select_n;
			sel_s2  <= sel_s1;
			sel_s3  <= sel_s2;
			si_s1   <= serial_in_line;
			si_s2   <= si_s1;
		end
	end

	wire sclk_rise = sclk_s2 & ~sclk_s3 & ~sel_s2;
	wire sclk_fall = ~sclk_s2 & sclk_s3 & ~sel_s2;
	wire sel_rise  = sel_s2 & ~sel_s3;

	// =========================================================
	// state
	reg  [11:0] bit_cnt;
	reg  [6:0]  sh_in;
	reg  [7:0]  cmd;
	reg  [23:0] addr;
	reg  [1:0]  area;
	reg  [7:0]  ptr;
	reg         op_ok;
	reg  [7:0]  tx_byte;
	reg         load_pend;
	reg  [6:0]  out_sh;
	reg         write_latch_flag;
	reg         quad_command_mode;
	reg         quad_enable_flag;
	reg  [2:0]  area_lock_bits;
	reg  [1:0]  dummy_count_field;
	reg  [1:0]  wrap_size_field;
	reg         rst_armed;
	reg         busy;
	reg         busy_erase;
	reg  [1:0]  busy_area;
	reg  [19:0] busy_cnt;
	reg  [7:0]  last_op;
	reg  [7:0]  sec_mem [0:1023]; // area 0 slot unused, keeps the index a plain concat

	wire [11:0] cnt_inc   = bit_cnt + 12'h001;
	wire [7:0]  rx_byte   = {sh_in, si_s2};
	wire        byte_done = sclk_rise && cnt_inc[2:0] == 3'b000;
	wire [8:0]  byte_num  = cnt_inc[11:3];
	wire        op_held   = busy && rx_byte != `FIS_OP_STAT1 && rx_byte != `FIS_OP_STAT2;
	wire [7:0]  op_now    = (byte_num == 9'd1) ? (op_held ? `FIS_OP_NONE : rx_byte) : cmd;
	wire [23:0] addr_full = {addr[15:0], rx_byte};
	wire [1:0]  area_full = fis_area(addr_full);
	wire        lock_hit  = area_full != 2'b00 && area_lock_bits[area_full - 2'b01];
	wire [7:0]  stat1     = {6'h00, write_latch_flag, busy};
	wire [7:0]  stat2     = {2'b00, area_lock_bits, 1'b0, quad_enable_flag, 1'b0};
	wire [31:0] busy_lim  = busy_erase ? {12'h000, ERASE_CYCLES} : {12'h000, PROG_CYCLES};
	wire        prog_we   = byte_done && cmd == `FIS_OP_SEC_PROG && op_ok &&
	                        byte_num >= `FIS_DATA_BYTE;
	wire        erase_we  = busy && busy_erase && busy_cnt < `FIS_AREA_BYTES;
	wire [7:0]  mem_rd    = sec_mem[{area, ptr}];
	wire        apb_wr    = psel && penable && pready && pwrite;

	// =========================================================
	// security area storage, programming only clears bits
	always @(posedge pclk)
	begin
		if (prog_we)
			sec_mem[{area, ptr}] <= mem_rd & rx_byte;
		else if (erase_we)
			sec_mem[{busy_area, busy_cnt[7:0]}] <= 8'hFF;
	end

	// =========================================================
	// serial command engine, busy timer and volatile settings
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_cnt           <= 12'h000;
			sh_in             <= 7'h00;
			cmd               <= `FIS_OP_NONE;
			addr              <= 24'h000000;
			area              <= 2'b00;
			ptr               <= 8'h00;
			op_ok             <= 1'b0;
			tx_byte           <= 8'hFF;
			load_pend         <= 1'b0;
			out_sh            <= 7'h7F;
			serial_out        <= 1'b1;
			serial_out_oe_n   <= 1'b1;
			write_latch_flag  <= 1'b0;
			quad_command_mode <= 1'b0;
			quad_enable_flag  <= 1'b0;
			area_lock_bits    <= 3'b000;
			dummy_count_field <= `FIS_DUMMY_RST;
			wrap_size_field   <= `FIS_WRAP_RST;
			rst_armed         <= 1'b0;
			busy              <= 1'b0;
			busy_erase        <= 1'b0;
			busy_area         <= 2'b00;
			busy_cnt          <= 20'h00000;
			last_op           <= `FIS_OP_NONE;
		end
		else
		begin
			// software side: quad enable is read/write, lock bits only ever set
			if (apb_wr && paddr == `FIS_REG_CONFIG)
			begin
				quad_enable_flag <= pwdata[0];
				area_lock_bits   <= area_lock_bits | pwdata[3:1];
			end

			// self-timed cycle; its end drops busy and the write latch flag
			if (busy)
			begin
				if ({12'h000, busy_cnt} + 32'h1 >= busy_lim)
				begin
					busy             <= 1'b0;
					write_latch_flag <= 1'b0;
				end
				busy_cnt <= busy_cnt + 20'h00001;
			end

			if (sel_s2)
			begin
				// select high: frame over, output released
				bit_cnt         <= 12'h000;
				load_pend       <= 1'b0;
				serial_out_oe_n <= 1'b1;
			end
			else if (sclk_rise)
			begin
				sh_in <= rx_byte[6:0];
				if (cnt_inc != 12'hFFF)
					bit_cnt <= cnt_inc;
			end

			// output shifts on falling edges, MSB first
			if (sclk_fall)
			begin
				if (load_pend)
				begin
					serial_out      <= tx_byte[7];
					out_sh          <= tx_byte[6:0];
					load_pend       <= 1'b0;
					serial_out_oe_n <= 1'b0;
				end
				else
				begin
					serial_out <= out_sh[6];
					out_sh     <= {out_sh[5:0], 1'b1};
				end
			end

			if (byte_done)
			begin
				if (byte_num == 9'd1)
				begin
					// while busy only status reads are taken
					if (op_held)
						cmd <= `FIS_OP_NONE;
					else
						cmd <= rx_byte;
					last_op <= rx_byte;
					op_ok   <= 1'b0;
					if (rx_byte != `FIS_OP_RST)
						rst_armed <= 1'b0;
				end
				else if (byte_num <= `FIS_ADDR_BYTE)
					addr <= addr_full;

				if (byte_num == `FIS_ADDR_BYTE)
				begin
					area <= area_full;
					ptr  <= addr_full[7:0];
					case (cmd)
						`FIS_OP_PARAM_RD:  op_ok <= addr_full[23:8] == 16'h0000;
						`FIS_OP_SEC_READ:  op_ok <= area_full != 2'b00;
						`FIS_OP_SEC_ERASE,
						`FIS_OP_SEC_PROG:  op_ok <= area_full != 2'b00 && !lock_hit &&
						                          write_latch_flag;
						default:           op_ok <= 1'b0;
					endcase
				end

				// read parameter byte, quad command mode only
				if (byte_num == 9'd2 && cmd == `FIS_OP_SET_RDPAR && quad_command_mode)
				begin
					dummy_count_field <= rx_byte[`FIS_DUMMY_MSB:`FIS_DUMMY_LSB];
					wrap_size_field   <= rx_byte[`FIS_WRAP_MSB:`FIS_WRAP_LSB];
				end

				// serial-mode wrap byte after three dummy bytes; kept across mode switch
				if (byte_num == `FIS_DATA_BYTE && cmd == `FIS_OP_SET_WRAP && !quad_command_mode)
					wrap_size_field <= rx_byte[5:4];

				if (prog_we)
					ptr <= ptr + 8'h01;

				// next byte to send
				load_pend <= 1'b0;
				case (op_now)
					`FIS_OP_JEDEC_ID:
					begin
						load_pend <= 1'b1;
						case (byte_num)
							9'd1:    tx_byte <= MFR_ID;
							9'd2:    tx_byte <= MEM_TYPE_ID;
							9'd3:    tx_byte <= CAPACITY_ID;
							default: tx_byte <= 8'h00;
						endcase
					end
					`FIS_OP_STAT1:
					begin
						load_pend <= 1'b1;
						tx_byte   <= stat1;
					end
					`FIS_OP_STAT2:
					begin
						load_pend <= 1'b1;
						tx_byte   <= stat2;
					end
					`FIS_OP_PARAM_RD:
						if (byte_num >= `FIS_DATA_BYTE)
						begin
							load_pend <= 1'b1;
							tx_byte   <= op_ok ? fis_table(ptr) : 8'hFF;
							ptr       <= ptr + 8'h01;
						end
					`FIS_OP_SEC_READ:
						if (byte_num >= `FIS_DATA_BYTE)
						begin
							load_pend <= 1'b1;
							tx_byte   <= op_ok ? mem_rd : 8'hFF;
							ptr       <= ptr + 8'h01;
						end
					default:
						tx_byte <= 8'hFF;
				endcase
			end

			// commands that act when select rises
			if (sel_rise)
			begin
				if (bit_cnt == 12'd8)
				begin
					case (cmd)
						`FIS_OP_WR_EN:    write_latch_flag <= 1'b1;
						`FIS_OP_WR_DIS:   write_latch_flag <= 1'b0;
						`FIS_OP_QUAD_IN:  if (quad_enable_flag)
							quad_command_mode <= 1'b1;
						`FIS_OP_QUAD_OUT: quad_command_mode <= 1'b0;
						`FIS_OP_RST_EN:   rst_armed <= 1'b1;
						`FIS_OP_RST:      if (rst_armed)
						begin
							// volatile settings back to power-on values
							write_latch_flag  <= 1'b0;
							quad_command_mode <= 1'b0;
							dummy_count_field <= `FIS_DUMMY_RST;
							wrap_size_field   <= `FIS_WRAP_RST;
							rst_armed         <= 1'b0;
							busy              <= 1'b0;
						end
						default:          rst_armed <= rst_armed;
					endcase
				end
				// erase only when select rises exactly after the 32nd bit
				if (cmd == `FIS_OP_SEC_ERASE && op_ok && bit_cnt == `FIS_ERASE_BITS)
				begin
					busy       <= 1'b1;
					busy_erase <= 1'b1;
					busy_area  <= area;
					busy_cnt   <= 20'h00000;
				end
				if (cmd == `FIS_OP_SEC_PROG && op_ok && bit_cnt >= `FIS_PROG_MIN_BIT &&
				    bit_cnt[2:0] == 3'b000)
				begin
					busy       <= 1'b1;
					busy_erase <= 1'b0;
					busy_cnt   <= 20'h00000;
				end
			end
		end
	end

	// =========================================================
	// apb slave, zero wait states; read data captured in the setup cycle, writes land in access
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata            <= 32'h00000000;
			pready            <= 1'b0;
			pslverr           <= 1'b0;
			read_dummy_clocks <= `FIS_SPI_DUMMY;
			wrap_bytes        <= 7'h08;
		end
		else
		begin
			pready <= 1'b1;
			// dummy count only matters to the quad fast, quad i/o and burst reads
			read_dummy_clocks <= quad_command_mode ? fis_dummy(dummy_count_field)
			                                       : `FIS_SPI_DUMMY;
			wrap_bytes <= fis_wrap(wrap_size_field);
			if (psel && !penable)
			begin
				pslverr <= 1'b0;
				case (paddr)
					`FIS_REG_STATUS: prdata <= {24'h000000, rst_armed, quad_command_mode,
					                            busy_erase, 3'b000, write_latch_flag, busy};
					`FIS_REG_CONFIG: prdata <= {28'h0000000, area_lock_bits, quad_enable_flag};
					`FIS_REG_RDPAR:  prdata <= {9'h000, fis_wrap(wrap_size_field), 4'h0,
					                            read_dummy_clocks, 2'b00,
					                            dummy_count_field, 2'b00, wrap_size_field};
					`FIS_REG_LASTOP: prdata <= {24'h000000, last_op};
					default:
					begin
						prdata  <= 32'h00000000;
						pslverr <= 1'b1; // unmapped address
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// file: fis_flash_cmd_monitor.sv
// checker watching the command block's bus and serial pins
`timescale 1ns/1ps
`default_nettype none
module fis_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        select_n,
	input wire logic        serial_out_oe_n,
	input wire logic [3:0]  read_dummy_clocks,
	input wire logic [6:0]  wrap_bytes
);
	// ==========================================
	// relations between inputs and outputs
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// only four aligned words answer without error
	wire logic mapped = (paddr[1:0] == 2'b00) && (paddr <= 8'h0C);
	wire logic rdpar = psel && penable && !pwrite && (paddr == 8'h08);

	bus_ready_a:
		assert property (psel && penable |-> pready) else $error("access without ready");
	bus_error_a:
		assert property (psel && penable |-> pslverr == !mapped) else $error("error flag wrong");
	reset_params_a:
		assert property ($rose(presetn) |-> wrap_bytes == 7'h08 && read_dummy_clocks == 4'h8)
		else $error("read parameters not at default");
	dummy_legal_a:
		assert property (read_dummy_clocks inside {4'h2, 4'h4, 4'h6, 4'h8})
		else $error("dummy count illegal");
	wrap_legal_a:
		assert property (wrap_bytes inside {7'h08, 7'h10, 7'h20, 7'h40}) else $error("wrap illegal");
	param_view_a:
		assert property (rdpar |-> prdata[11:8] == read_dummy_clocks && prdata[22:16] == wrap_bytes)
		else $error("parameter register disagrees with outputs");
	wrap_decode_a:
		assert property (rdpar |-> prdata[22:16] == (7'h08 << prdata[1:0]))
		else $error("wrap field decoded wrongly");
	oe_release_a:
		assert property ($rose(select_n) |-> ##[1:6] serial_out_oe_n) else $error("output not released");
	oe_idle_a:
		assert property (select_n [*8] |-> serial_out_oe_n) else $error("output driven while idle");
endmodule
`default_nettype wire

// file: fis_host_model.sv
// host serial controller model that drives select, clock and data in
`timescale 1ns/1ps
`default_nettype none
module fis_host_model (
	output var logic select_n,
	output var logic serial_clk,
	output var logic serial_in_line,
	input wire logic serial_out,
	input wire logic serial_out_oe_n
);
	// ==========================================
	// frame engine
	logic [31:0] rx;
	logic        drove;
	// a released data line floats up to its pull-up level
	wire logic   so_line = serial_out_oe_n ? 1'b1 : serial_out;
	// idle: select high, clock parked low between frames
	initial
	begin
		select_n = 1'b1;
		serial_clk = 1'b0;
		serial_in_line = 1'b0;
	end
	// 8 MHz clock keeps inside the slowest read limit
	task automatic xfer(input logic [63:0] tx, input int nb, input int nr);
		int k;
		rx = 32'h0;
		drove = 1'b0;
		select_n = 1'b0;
		for (k = 0; k < (nb + nr) * 8; k++)
		begin
			// toggle data in once nothing is sent, so no stale level hides a fault
			serial_in_line = (k < nb * 8) ? tx[63 - k] : ~serial_in_line;
			#62.5 serial_clk = 1'b1;
			rx = (k < nb * 8) ? rx : {rx[30:0], so_line};
			drove = drove | ((k >= nb * 8) && !serial_out_oe_n);
			#62.5 serial_clk = 1'b0;
		end
		// select rises right after the last bit was latched
		#62.5 select_n = 1'b1;
		#100;
	endtask
endmodule
`default_nettype wire

// file: fis_flash_cmd_tb.sv
// self-checking bench for the flash command block
`timescale 1ns/1ps
`default_nettype none
module fis_flash_cmd_tb;
	// ==========================================
	// signals and instances
	localparam logic [7:0] MFR = 8'hC3; // arbitrary value
	localparam logic [7:0] TYP = 8'h3C; // arbitrary value
	localparam logic [7:0] CAP = 8'h11; // arbitrary value
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic        serial_out, serial_out_oe_n;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  read_dummy_clocks;
	logic [6:0]  wrap_bytes;
	wire logic   select_n, serial_clk, serial_in_line;
	int          err_count, total_checks, i;

	fis_flash_cmd #(.ERASE_CYCLES(20'd1500), .PROG_CYCLES(20'd20), .MFR_ID(MFR),
		.MEM_TYPE_ID(TYP), .CAPACITY_ID(CAP)) i_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .select_n, .serial_clk,
		.serial_in_line, .serial_out, .serial_out_oe_n, .read_dummy_clocks, .wrap_bytes);
	fis_host_model i_host (.select_n, .serial_clk, .serial_in_line, .serial_out,
		.serial_out_oe_n);

	// ==========================================
	// tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one bus transfer; the request holds until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no bound here: only the watchdog ends a wait
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll the busy flag, bounded
	task automatic wait_idle;
		int n;
		n = 0;
		r = 32'h1;
		while (r[0] !== 1'b0 && n < 500)
		begin
			apb(1'b0, 8'h00, 32'h0);
			n++;
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==========================================
	// clock, watchdog and tests
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// the tests need about 11500 cycles; the limit allows over twice that
	initial
	begin
		#300000;
		err_count++;
		print_verdict;
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		err_count = 0;
		total_checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		i_host.xfer({8'h9F, 56'h0}, 1, 4);
		chk("id bytes", i_host.rx, {MFR, TYP, CAP, 8'h00});
		i_host.xfer({8'h5A, 56'h0}, 5, 4);
		chk("table start", i_host.rx, 32'h5346_4450);
		i_host.xfer({8'h5A, 24'h000005, 32'h0}, 5, 4);
		chk("table offset", i_host.rx, 32'h0100_FFFF);
		i_host.xfer({8'h5A, 24'h000100, 32'h0}, 5, 1);
		chk("table bad address", i_host.rx, 32'hFF);
		$display("test identification and table done");
		i_host.xfer({8'h44, 24'h001000, 32'h0}, 4, 0);
		apb(1'b0, 8'h00, 32'h0);
		chk("erase without latch", r[1:0], 2'b00);
		i_host.xfer({8'h06, 56'h0}, 1, 0);
		i_host.xfer({8'h44, 24'h001000, 32'h0}, 5, 0);
		apb(1'b0, 8'h00, 32'h0);
		chk("erase late select", r[1:0], 2'b10);
		i_host.xfer({8'h44, 24'h001000, 32'h0}, 4, 0);
		apb(1'b0, 8'h00, 32'h0);
		chk("erase busy", r[1:0], 2'b11);
		i_host.xfer({8'h05, 56'h0}, 1, 1);
		chk("status during erase", i_host.rx, 32'h3);
		i_host.xfer({8'h48, 24'h001000, 32'h0}, 5, 1);
		chk("read while busy", i_host.drove, 1'b0);
		i_host.xfer({8'h9F, 56'h0}, 1, 1);
		chk("id while busy", i_host.drove, 1'b0);
		wait_idle;
		chk("erase end", r[1:0], 2'b00);
		i_host.xfer({8'h06, 56'h0}, 1, 0);
		i_host.xfer({8'h42, 24'h0010FE, 16'hABCD, 16'h0}, 6, 0);
		wait_idle;
		i_host.xfer({8'h48, 24'h0010FE, 32'h0}, 5, 3);
		chk("area read wrap", i_host.rx, 32'hABCDFF);
		i_host.xfer({8'h48, 24'h001100, 32'h0}, 5, 1);
		chk("bad area address", i_host.rx, 32'hFF);
		$display("test security areas done");
		apb(1'b1, 8'h04, 32'h2);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk("lock sticks", r[3:1], 3'b001);
		i_host.xfer({8'h06, 56'h0}, 1, 0);
		i_host.xfer({8'h44, 24'h001000, 32'h0}, 4, 0);
		apb(1'b0, 8'h00, 32'h0);
		chk("locked erase", r[0], 1'b0);
		i_host.xfer({8'h48, 24'h0010FE, 32'h0}, 5, 1);
		chk("locked data kept", i_host.rx, 32'hAB);
		$display("test lock done");
		i_host.xfer({8'hC0, 8'h33, 48'h0}, 2, 0);
		chk("param in serial", {read_dummy_clocks, wrap_bytes}, {4'h8, 7'h08});
		i_host.xfer({8'h77, 24'h0, 8'h20, 24'h0}, 5, 0);
		chk("serial wrap", wrap_bytes, 7'h20);
		i_host.xfer({8'h38, 56'h0}, 1, 0);
		apb(1'b0, 8'h00, 32'h0);
		chk("quad refused", r[6], 1'b0);
		apb(1'b1, 8'h04, 32'h1);
		i_host.xfer({8'h38, 56'h0}, 1, 0);
		apb(1'b0, 8'h00, 32'h0);
		chk("quad entered", r[6], 1'b1);
		chk("wrap kept", wrap_bytes, 7'h20);
		chk("quad dummy default", read_dummy_clocks, 4'h2);
		// every dummy and wrap code, programmed before any read
		for (i = 0; i < 4; i++)
		begin
			i_host.xfer({8'hC0, 2'b00, i[1:0], 2'b00, i[1:0], 48'h0}, 2, 0);
			apb(1'b0, 8'h08, 32'h0);
			chk("dummy decode", read_dummy_clocks, 2 * i + 2);
			chk("wrap decode", wrap_bytes, 8 << i);
			chk("param fields", {r[5:4], r[1:0]}, {i[1:0], i[1:0]});
		end
		i_host.xfer({8'h66, 56'h0}, 1, 0);
		i_host.xfer({8'h99, 56'h0}, 1, 0);
		chk("reset params", {read_dummy_clocks, wrap_bytes}, {4'h8, 7'h08});
		apb(1'b0, 8'h00, 32'h0);
		chk("reset mode", r[6], 1'b0);
		apb(1'b0, 8'h08, 32'h0);
		chk("reset fields", r[11:0], 12'h800);
		apb(1'b1, 8'h10, 32'hFFFF_FFFF);
		chk("unmapped error", e, 1'b1);
		$display("test read parameters done");
		print_verdict;
	end
endmodule

bind fis_flash_cmd fis_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .select_n, .serial_out_oe_n, .read_dummy_clocks, .wrap_bytes);
`default_nettype wire
